// ===== hw/free_running_timer_counter.sv
// Free-running 16-bit timer counter with AXI4-Lite register access
// Overview of operation
// - Counter advances on tick: clock divided by 2, 4 or 8.
// - Internal period is 65536 ticks: 131072, 262144 or 524288 clocks.
// - Main and alternate pairs show the same count in two bytes.
// - Writing either low byte forces the counter to FFFCh.
// - Reset starts the counter at FFFCh, the only loaded value.
// - High byte read first latches low byte for a coherent read.
// - Buffered low byte holds until the low byte is read.
// - Low byte read outside a sequence returns the live low byte.
// - Wrap from FFFFh to 0000h sets the wrap flag.
// - Interrupt only when enabled and CPU mask clear; else pending.
// - Flag clears after status read, then main low byte access.
// - Alternate low byte accesses never clear the wrap flag.
// - Counter keeps running in wait mode.
// - Halt freezes counter; wake resumes; reset restarts at FFFCh.
// - Both select bits set chooses the external count pin.
// - Edge select picks rising or falling external edges.
// - External edges are synchronised before counting.
// - Unbonded timer input reads as logic 1.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module free_running_timer_counter
    import timer_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        halt_mode,
    input  wire logic        cpu_irq_mask,
    input  wire logic        ext_present,
    input  wire logic        ext_count_pin,
    output      logic        wrap_irq
);

    // ************************************************************
    // State
    // ************************************************************
    logic [15:0]    count;
    logic [7:0]     low_buffer;
    logic           low_frozen;
    logic           wrap_flag;
    logic           flag_armed;
    control_type    control;
    logic           aw_held;
    logic           w_held;
    logic [7:0]     aw_addr;
    logic [7:0]     w_data;
    logic           w_lane0;
    wire  logic     tick;
    wire  logic     run;
    wire  logic     wr_fire;
    wire  logic     rd_fire;
    wire  logic [7:0] rd_addr;
    wire  logic     wr_low;
    wire  logic     wr_main_low;
    wire  logic     wr_ctrl;
    wire  logic     rd_high;
    wire  logic     rd_low;
    wire  logic     rd_main_low;
    wire  logic     rd_flags;
    wire  logic     main_low_access;
    wire  logic     wrap_event;
    wire  logic     rd_mapped;
    wire  logic     wr_mapped;
    wire  logic [7:0] low_view;
    wire  logic [31:0] next_rdata;
    wire  logic [15:0] next_count;
    wire  logic     aw_take;
    wire  logic     w_take;
    wire  logic     next_awready;
    wire  logic     next_wready;
    wire  logic     next_arready;
    wire  logic     rd_is_high;
    wire  logic     rd_is_low;
    wire  logic     rd_is_flags;
    wire  logic     rd_is_ctrl;
    wire  logic     aw_is_low;
    wire  logic     aw_is_ctrl;
    wire  logic [1:0] next_bresp;
    wire  logic [1:0] next_rresp;

    // ************************************************************
    // Address decode helpers
    // ************************************************************
    function automatic logic is_low(input logic [7:0] a);
        return (a == count_low_off) || (a == alt_count_low_off);
    endfunction

    function automatic logic is_high(input logic [7:0] a);
        return (a == count_high_off) || (a == alt_count_high_off);
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return is_high(a) || is_low(a) || (a == timer_flags_off)
               || (a == timer_control_off);
    endfunction

    // ************************************************************
    // Prescaler and count enable
    // ************************************************************
    // wait mode ignored
    assign run = ~halt_mode;

    tick_gen u_tick (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .run           (run),
        .select        (control.select),
        .edge_rising   (control.edge_rising),
        .ext_present   (ext_present),
        .ext_count_pin (ext_count_pin),
        .tick          (tick)
    );

    // ************************************************************
    // Bus decode
    // ************************************************************
    // One write at a time: fire only once both halves are held
    assign wr_fire     = aw_held & w_held & ~s_axi_bvalid;
    assign aw_take     = s_axi_awvalid & s_axi_awready;
    assign w_take      = s_axi_wvalid & s_axi_wready;
    assign rd_fire     = s_axi_arvalid & s_axi_arready;
    assign rd_addr     = s_axi_araddr;
    assign rd_is_high  = is_high(rd_addr);
    assign rd_is_low   = is_low(rd_addr);
    assign rd_is_flags = (rd_addr == timer_flags_off);
    assign rd_is_ctrl  = (rd_addr == timer_control_off);
    assign aw_is_low   = is_low(aw_addr);
    assign aw_is_ctrl  = (aw_addr == timer_control_off);
    // Register data lives in byte lane 0 only
    assign wr_low      = wr_fire & w_lane0 & aw_is_low;
    assign wr_main_low = wr_fire & (aw_addr == count_low_off);
    assign wr_ctrl     = wr_fire & w_lane0 & aw_is_ctrl;
    assign rd_high     = rd_fire & rd_is_high;
    assign rd_low      = rd_fire & rd_is_low;
    assign rd_main_low = rd_fire & (rd_addr == count_low_off);
    assign rd_flags    = rd_fire & rd_is_flags;
    assign rd_mapped   = is_mapped(rd_addr);
    assign wr_mapped   = is_mapped(aw_addr);
    assign next_bresp  = wr_mapped ? resp_okay : resp_slverr;
    assign next_rresp  = rd_mapped ? resp_okay : resp_slverr;
    // Ready pulses one cycle, never while an answer is pending
    assign next_awready = ~aw_held & ~s_axi_awready & ~s_axi_bvalid;
    assign next_wready  = ~w_held & ~s_axi_wready & ~s_axi_bvalid;
    assign next_arready = ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;

    assign main_low_access = wr_main_low | rd_main_low;

    // ************************************************************
    // Counter
    // ************************************************************
    // full 16-bit wrap
    assign next_count = 16'(count + 16'h0001);
    assign wrap_event = tick & (count == 16'hffff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= count_reset_value;
        end else if (wr_low) begin
            count <= count_reset_value;
        end else if (tick) begin
            count <= next_count;
        end
    end

    // ************************************************************
    // Coherent 16-bit read
    // ************************************************************
    // latch low on high read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_frozen <= 1'b0;
            low_buffer <= 8'h00;
        end else if (rd_low) begin
            low_frozen <= 1'b0;
        end else if (rd_high && !low_frozen) begin
            low_frozen <= 1'b1;
            low_buffer <= count[7:0];
        end
    end

    assign low_view = low_frozen ? low_buffer : count[7:0];

    // ************************************************************
    // Read data
    // ************************************************************
    // both pairs same count
    assign next_rdata =
        rd_is_high  ? {24'h0, count[15:8]} :
        rd_is_low   ? {24'h0, low_view} :
        rd_is_flags ? 32'({wrap_flag, 7'h00}) :
        rd_is_ctrl  ? {28'h0, control} :
                      32'h0;

    // ************************************************************
    // Wrap flag and interrupt
    // ************************************************************
    // two-step clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_flag  <= 1'b0;
            flag_armed <= 1'b0;
        end else if (wrap_event) begin
            wrap_flag  <= 1'b1;
            // A main low access in the same cycle spends the arming
            flag_armed <= ~main_low_access
                          & (flag_armed | (rd_flags & wrap_flag));
        end else if (main_low_access && flag_armed) begin
            wrap_flag  <= 1'b0;
            flag_armed <= 1'b0;
        end else if (rd_flags && wrap_flag) begin
            flag_armed <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wrap_irq <= 1'b0;
        end else begin
            wrap_irq <= wrap_flag & control.irq_enable & ~cpu_irq_mask;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            control <= control_type'(control_reset_value);
        end else if (wr_ctrl) begin
            control <= control_type'(w_data[3:0]);
        end
    end

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
        end
    end

    // Address half waits here until its data half arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (aw_take) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    // Only byte lane 0 is kept: every register is one byte wide
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            w_data  <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (w_take) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held  <= 1'b0;
        end
    end

    // Response stands until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= next_bresp;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= next_arready;
        end
    end

    // Read data is captured at the address handshake and then held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= resp_okay;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== hw/tick_gen.sv
// Count-enable source: internal divider or synchronised external edges
`timescale 1ns/1ns
module tick_gen
    import timer_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                run,
    input  wire prescale_select_type select,
    input  wire logic                edge_rising,
    input  wire logic                ext_present,
    input  wire logic                ext_count_pin,
    output      logic                tick
);

    logic [2:0] div_count;
    logic       ext_sync1;
    logic       ext_sync2;
    logic       ext_prev;
    wire  logic ext_level;
    wire  logic [2:0] div_last;
    wire  logic div_done;
    wire  logic ext_edge;
    wire  logic next_tick;

    assign ext_level = ext_present ? ext_count_pin : unbonded_level;
    assign div_last  = (select == sel_div2) ? div2_last :
                       (select == sel_div4) ? div4_last : div8_last;
    // A shorter ratio chosen mid-count still ends the period
    assign div_done  = (div_count >= div_last);
    assign ext_edge  = edge_rising ? (ext_sync2 & ~ext_prev)
                                   : (~ext_sync2 & ext_prev);
    assign next_tick = run & ((select == sel_ext) ? ext_edge
                                                  : div_done);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_count <= 3'h0;
        end else if (run) begin
            div_count <= div_done ? 3'h0 : 3'(div_count + 3'h1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_sync1 <= 1'b1;
            ext_sync2 <= 1'b1;
            ext_prev  <= 1'b1;
            tick      <= 1'b0;
        end else begin
            ext_sync1 <= ext_level;
            ext_sync2 <= ext_sync1;
            ext_prev  <= ext_sync2;
            tick      <= next_tick;
        end
    end

endmodule

// ===== hw/timer_pkg.sv
// Package of constants and types for the free-running timer counter
package timer_pkg;

    // ************************************************************
    // Register byte addresses on the AXI4-Lite bus
    // ************************************************************
    localparam logic [7:0] count_high_off      = 8'h00;
    localparam logic [7:0] count_low_off       = 8'h04;
    localparam logic [7:0] alt_count_high_off  = 8'h08;
    localparam logic [7:0] alt_count_low_off   = 8'h0c;
    localparam logic [7:0] timer_flags_off     = 8'h10;
    localparam logic [7:0] timer_control_off   = 8'h14;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int         sel_lsb_pos         = 0;
    localparam int         sel_msb_pos         = 1;
    localparam int         edge_pos            = 2;
    localparam int         irq_en_pos          = 3;
    localparam int         wrap_flag_pos       = 7;
    localparam logic [15:0] count_reset_value  = 16'hfffc;
    localparam logic [3:0] control_reset_value = 4'h0;
    localparam logic [1:0] resp_okay           = 2'b00;
    localparam logic [1:0] resp_slverr         = 2'b10;
    localparam logic       unbonded_level      = 1'b1;

    // ************************************************************
    // Prescaler divide terminal counts (divide by 2, 4, 8)
    // ************************************************************
    localparam logic [2:0] div2_last           = 3'h1;
    localparam logic [2:0] div4_last           = 3'h3;
    localparam logic [2:0] div8_last           = 3'h7;

    typedef enum logic [1:0] {
        sel_div2 = 2'b00,
        sel_div4 = 2'b01,
        sel_div8 = 2'b10,
        sel_ext  = 2'b11
    } prescale_select_type;

    typedef struct packed {
        logic                irq_enable;
        logic                edge_rising;
        prescale_select_type select;
    } control_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       is_write;
        logic [7:0] wdata;
    } reg_access_type;

endpackage

// ===== testbench/free_running_timer_counter_tb.sv
// Self-checking bench for the free-running timer counter
`timescale 1ns/1ns
module free_running_timer_counter_tb;
    import timer_pkg::*;
    logic        aclk;
    logic        aresetn = 1'b0, halt_mode = 1'b1, cpu_irq_mask = 1'b1;
    logic        ext_present = 1'b1, ext_count_pin = 1'b0, wrap_irq;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [15:0] a0, a1;
    int          err_total = 0, checks_done = 0;
    // Address, expected byte, expected response
    localparam logic [17:0] rows [7] = '{
        {8'h00, 8'hff, resp_okay}, {8'h04, 8'hfc, resp_okay},
        {8'h08, 8'hff, resp_okay}, {8'h0c, 8'hfc, resp_okay},
        {8'h10, 8'h00, resp_okay}, {8'h14, 8'h00, resp_okay},
        {8'h18, 8'h00, resp_slverr}};
    free_running_timer_counter uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .halt_mode(halt_mode),
        .cpu_irq_mask(cpu_irq_mask), .ext_present(ext_present),
        .ext_count_pin(ext_count_pin), .wrap_irq(wrap_irq)
    );
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dv);
        @(posedge aclk);
        awaddr <= ad;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] dv);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        dv = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd16(input logic [7:0] b, output logic [15:0] v);
        rd(b, d);
        v[15:8] = d[7:0];
        rd(b + 8'h04, d);
        v[7:0] = d[7:0];
    endtask
    task automatic run(input int n);
        halt_mode <= 1'b0;
        repeat (n) @(posedge aclk);
        halt_mode <= 1'b1;
    endtask
    task automatic rst;
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic pin(input logic v, input logic [15:0] dlt);
        rd16(count_high_off, a0);
        ext_count_pin <= v;
        repeat (12) @(posedge aclk);
        rd16(count_high_off, a1);
        chk(16'(a1 - a0), dlt);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        final_report();
    end
    // ********
    // Sequence
    // ********
    initial begin
        rst();
        foreach (rows[i]) begin
            rd(rows[i][17:10], d);
            chk(d, {24'h0, rows[i][9:2]});
            chk({30'h0, r}, {30'h0, rows[i][1:0]});
        end
        wr(8'h18, 32'h0);
        chk({30'h0, r}, {30'h0, resp_slverr});
        for (int k = 0; k < 3; k++) begin
            wr(timer_control_off, 32'(k));
            wr(count_low_off, 32'h0);
            run(16 << k);
            rd16(count_high_off, a0);
            run(128 << k);
            rd16(alt_count_high_off, a1);
            chk(16'(a1 - a0), 32'd64);
        end
        rd(timer_flags_off, d);
        chk(d, 32'h80);
        wr(timer_control_off, 32'h08);
        repeat (6) @(posedge aclk);
        chk(wrap_irq, 1'b0);
        cpu_irq_mask <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(wrap_irq, 1'b1);
        rd(alt_count_low_off, d);
        rd(timer_flags_off, d);
        chk(d, 32'h80);
        rd(count_low_off, d);
        rd(timer_flags_off, d);
        chk(d, 32'h00);
        chk(wrap_irq, 1'b0);
        run(40);
        wr(alt_count_low_off, 32'h0);
        rd16(count_high_off, a0);
        chk(a0, 16'hfffc);
        repeat (20) @(posedge aclk);
        rd16(alt_count_high_off, a1);
        chk(a1, a0);
        rd(count_high_off, d);
        run(40);
        rd(alt_count_high_off, d);
        rd(count_low_off, d);
        chk(d, 32'hfc);
        rd(alt_count_low_off, d);
        rd16(count_high_off, a1);
        chk(d, 32'h10);
        chk(a1, 16'h0010);
        wr(timer_control_off, 32'h07);
        halt_mode <= 1'b0;
        pin(1'b1, 16'd1);
        pin(1'b0, 16'd0);
        wr(timer_control_off, 32'h03);
        pin(1'b1, 16'd0);
        pin(1'b0, 16'd1);
        pin(1'b1, 16'd0);
        ext_present <= 1'b0;
        pin(1'b0, 16'd0);
        halt_mode <= 1'b1;
        rst();
        rd16(count_high_off, a0);
        chk(a0, 16'hfffc);
        final_report();
    end
endmodule

// ===== testbench/timer_checker_assertions.sv
// Port-level assertions for the free-running timer counter
`timescale 1ns/1ns
module timer_checker
    import timer_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        cpu_irq_mask,
    input wire logic        wrap_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ********
    // Bus and interrupt checks
    // ********
    ar_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("arready longer than one cycle");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    busy_refuse_a: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    slverr_zero_a: assert property (s_axi_rvalid
        && s_axi_rresp == resp_slverr |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    byte_lane_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above the byte lane");
    irq_masked_a: assert property (
        wrap_irq |-> !$past(cpu_irq_mask))
        else $error("interrupt while masked");
    irq_pending_a: assert property (
        (wrap_irq && !cpu_irq_mask && !s_axi_arvalid && !s_axi_awvalid
        && !s_axi_wvalid) [*4] |=> wrap_irq)
        else $error("pending interrupt dropped");
endmodule
bind free_running_timer_counter timer_checker port_checks (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .cpu_irq_mask(cpu_irq_mask), .wrap_irq(wrap_irq)
);
